// ===== hw/cpualu_unit.sv
// arithmetic, logic and shift datapath of an 8/16-bit cpu core
// assumes the decoder presents one operation with a start pulse and
// waits for DONE; flags are held here and written on each operation
//
// Operation
// RQ1: add or subtract register operands, byte or word; add immediate.
// RQ2: plain subtract takes register operands only, never immediate.
// RQ3: word add and subtract need two registers; immediate is byte only.
// RQ4: byte add/subtract with carry, register or immediate operand.
// RQ5: byte increment and decrement change a register by exactly one.
// RQ6: word adjust adds or subtracts one or two.
// RQ7: decimal adjust fixes byte sum or difference using flags.
// RQ8: unsigned 8 by 8 multiply gives a full 16-bit result.
// RQ9: unsigned 16 by 8 divide gives 8-bit quotient and remainder.
// RQ10: compare subtracts, updates flags, leaves destination unchanged.
// RQ11: word compare between registers only; immediate compare is byte.
// RQ12: negate gives zero minus the byte register.
// RQ13: byte AND with register or immediate into destination.
// RQ14: byte OR with register or immediate into destination.
// RQ15: byte XOR with register or immediate into destination.
// RQ16: byte NOT inverts every bit in place.
// RQ17: arithmetic shifts by one; right shift keeps the sign bit.
// RQ18: logical shifts by one fill the vacated bit with zero.
// RQ19: rotates by one feed the leaving bit back in.
// RQ20: rotate through carry forms a nine-bit loop.
// RQ21: flag word holds negative, zero, overflow and carry.
// RQ22: shifts and rotates copy the bit shifted out into carry.
// RQ23: negative from result sign, zero when result is all zero; divide takes both from the divisor, carry forms keep zero only if set.
`timescale 1ns/1ps
module cpualu_unit
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic START,
   input wire cpualu_pkg::cpualu_op_t OP,
   input wire logic WORD,
   input wire logic USE_IMM,
   input wire logic SUB_TWO,
   input wire logic [15:0] DST_IN,
   input wire logic [15:0] SRC_IN,
   input wire logic [7:0] IMM,
   output logic DONE,
   output logic ILLEGAL,
   output logic WRITE_EN,
   output logic [15:0] RESULT,
   output logic [3:0] FLAGS
);
   import cpualu_pkg::*;

   logic [3:0] flag_word_r;
   logic [3:0] flag_nxt;
   logic [15:0] res_nxt;
   logic wr_nxt;
   logic bad_nxt;
   logic [7:0] a8;
   logic [7:0] b8;
   logic [8:0] sum9;
   logic [16:0] sum17;
   logic [7:0] adj;
   logic c_in;
   logic div_start;
   logic div_done;
   logic [7:0] div_q;
   logic [7:0] div_r;
   cpualu_state_t state_r;

   // byte flags from a result, overflow and carry supplied
   function automatic logic [3:0] flags8(input logic [7:0] r,
                                         input logic v,
                                         input logic c);
      flags8 = {r[7], r == 8'h00, v, c}; // RQ23
   endfunction : flags8

   function automatic logic [3:0] flags16(input logic [15:0] r,
                                          input logic v,
                                          input logic c);
      flags16 = {r[15], r == 16'h0000, v, c}; // RQ23
   endfunction : flags16

   assign a8 = DST_IN[7:0];
   assign b8 = USE_IMM ? IMM : SRC_IN[7:0];
   assign c_in = flag_word_r[FLAG_C];
   assign div_start = START && (OP == OP_DIVIDE) && (state_r == ST_IDLE);

   cpualu_divider #(.STEPS(DIV_STEPS)) u_div
   (
      .clk(MCLK),
      .rst(RST),
      .start(div_start),
      .dividend(DST_IN),
      .divisor(SRC_IN[7:0]),
      .done(div_done),
      .quotient(div_q),
      .remainder(div_r)
   );

   always_comb
   begin
      res_nxt = DST_IN;
      flag_nxt = flag_word_r;
      wr_nxt = 1'b1;
      bad_nxt = 1'b0;
      sum9 = 9'h000;
      sum17 = 17'h00000;
      adj = 8'h00;
      unique case (OP)
         OP_ADD:
         begin
            if (WORD && USE_IMM)
               bad_nxt = 1'b1; // RQ3
            else if (WORD)
            begin
               sum17 = {1'b0, DST_IN} + {1'b0, SRC_IN}; // RQ1
               res_nxt = sum17[15:0];
               flag_nxt = flags16(sum17[15:0],
                  (DST_IN[15] == SRC_IN[15]) &&
                  (sum17[15] != DST_IN[15]), sum17[16]);
            end
            else
            begin
               sum9 = {1'b0, a8} + {1'b0, b8}; // RQ1
               res_nxt = {DST_IN[15:8], sum9[7:0]};
               flag_nxt = flags8(sum9[7:0],
                  (a8[7] == b8[7]) && (sum9[7] != a8[7]), sum9[8]);
            end
         end
         OP_SUB, OP_COMPARE:
         begin
            if (USE_IMM && (OP == OP_SUB || WORD))
               bad_nxt = 1'b1; // RQ2 RQ3 RQ11
            else if (WORD)
            begin
               sum17 = {1'b0, DST_IN} - {1'b0, SRC_IN}; // RQ1
               res_nxt = sum17[15:0];
               flag_nxt = flags16(sum17[15:0],
                  (DST_IN[15] != SRC_IN[15]) &&
                  (sum17[15] != DST_IN[15]), sum17[16]);
            end
            else
            begin
               sum9 = {1'b0, a8} - {1'b0, b8}; // RQ1
               res_nxt = {DST_IN[15:8], sum9[7:0]};
               flag_nxt = flags8(sum9[7:0],
                  (a8[7] != b8[7]) && (sum9[7] != a8[7]), sum9[8]);
            end
            if (OP == OP_COMPARE)
               wr_nxt = 1'b0; // RQ10
         end
         OP_ADD_WITH_CARRY:
         begin
            sum9 = {1'b0, a8} + {1'b0, b8} + {8'h00, c_in}; // RQ4
            res_nxt = {DST_IN[15:8], sum9[7:0]};
            flag_nxt = flags8(sum9[7:0],
               (a8[7] == b8[7]) && (sum9[7] != a8[7]), sum9[8]);
            // zero only stays set across a multi-byte chain
            flag_nxt[FLAG_Z] = flag_word_r[FLAG_Z] && sum9[7:0] == 8'h00;
         end
         OP_SUB_WITH_BORROW:
         begin
            sum9 = {1'b0, a8} - {1'b0, b8} - {8'h00, c_in}; // RQ4
            res_nxt = {DST_IN[15:8], sum9[7:0]};
            flag_nxt = flags8(sum9[7:0],
               (a8[7] != b8[7]) && (sum9[7] != a8[7]), sum9[8]);
            flag_nxt[FLAG_Z] = flag_word_r[FLAG_Z] && sum9[7:0] == 8'h00;
         end
         OP_PLUS_ONE, OP_MINUS_ONE:
         begin
            adj = (OP == OP_PLUS_ONE) ? a8 + 8'h01 : a8 - 8'h01; // RQ5
            res_nxt = {DST_IN[15:8], adj};
            // carry is left alone by increment and decrement
            flag_nxt = flags8(adj, (OP == OP_PLUS_ONE) ?
               (a8 == 8'h7F) : (a8 == 8'h80), c_in);
         end
         OP_WORD_PLUS:
         begin
            res_nxt = DST_IN + (SUB_TWO ? 16'h0002 : 16'h0001); // RQ6
         end
         OP_WORD_MINUS:
         begin
            res_nxt = DST_IN - (SUB_TWO ? 16'h0002 : 16'h0001); // RQ6
         end
         OP_BCD_FIX_ADD:
         begin
            adj = 8'h00;
            if (flag_word_r[FLAG_C] || a8 > 8'h99)
               adj[7:4] = 4'h6; // RQ7
            if (a8[3:0] > 4'h9)
               adj[3:0] = 4'h6; // RQ7
            sum9 = {1'b0, a8} + {1'b0, adj};
            res_nxt = {DST_IN[15:8], sum9[7:0]};
            flag_nxt = flags8(sum9[7:0], 1'b0,
               flag_word_r[FLAG_C] || a8 > 8'h99);
         end
         OP_BCD_FIX_SUB:
         begin
            adj = 8'h00;
            if (a8[3:0] > 4'h9)
               adj[3:0] = 4'hA; // RQ7
            // borrow on both digits needs minus 0x66, that is plus 0x9A
            if (flag_word_r[FLAG_C])
               adj[7:4] = (a8[3:0] > 4'h9) ? 4'h9 : 4'hA; // RQ7
            else if (a8[3:0] > 4'h9)
               adj[7:4] = 4'hF;
            sum9 = {1'b0, a8} + {1'b0, adj};
            res_nxt = {DST_IN[15:8], sum9[7:0]};
            flag_nxt = flags8(sum9[7:0], 1'b0, flag_word_r[FLAG_C]);
         end
         OP_MULTIPLY:
         begin
            res_nxt = 16'(a8 * SRC_IN[7:0]); // RQ8
         end
         OP_DIVIDE:
         begin
            res_nxt = {div_r, div_q}; // RQ9
            flag_nxt[FLAG_Z] = SRC_IN[7:0] == 8'h00;
            flag_nxt[FLAG_N] = SRC_IN[7];
         end
         OP_NEGATE:
         begin
            adj = 8'h00 - a8; // RQ12
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, a8 == 8'h80, a8 != 8'h00);
         end
         OP_AND, OP_OR, OP_XOR, OP_NOT:
         begin
            unique case (OP)
               OP_AND: adj = a8 & b8; // RQ13
               OP_OR: adj = a8 | b8; // RQ14
               OP_XOR: adj = a8 ^ b8; // RQ15
               default: adj = ~a8; // RQ16
            endcase
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, 1'b0, c_in);
         end
         OP_ARITH_LEFT, OP_LOGIC_LEFT:
         begin
            adj = {a8[6:0], 1'b0}; // RQ17 RQ18
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, 1'b0, a8[7]); // RQ22
         end
         OP_ARITH_RIGHT:
         begin
            adj = {a8[7], a8[7:1]}; // RQ17
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, 1'b0, a8[0]); // RQ22
         end
         OP_LOGIC_RIGHT:
         begin
            adj = {1'b0, a8[7:1]}; // RQ18
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, 1'b0, a8[0]); // RQ22
         end
         OP_CIRC_LEFT:
         begin
            adj = {a8[6:0], a8[7]}; // RQ19
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, 1'b0, a8[7]); // RQ22
         end
         OP_CIRC_RIGHT:
         begin
            adj = {a8[0], a8[7:1]}; // RQ19
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, 1'b0, a8[0]); // RQ22
         end
         OP_CARRY_LEFT:
         begin
            adj = {a8[6:0], c_in}; // RQ20
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, 1'b0, a8[7]); // RQ22
         end
         OP_CARRY_RIGHT:
         begin
            adj = {c_in, a8[7:1]}; // RQ20
            res_nxt = {DST_IN[15:8], adj};
            flag_nxt = flags8(adj, 1'b0, a8[0]); // RQ22
         end
         default:
         begin
            bad_nxt = 1'b1;
         end
      endcase
      if (bad_nxt)
      begin
         res_nxt = DST_IN;
         flag_nxt = flag_word_r;
         wr_nxt = 1'b0;
      end
   end

   // sequencing: single-cycle ops answer next edge, divide waits
   always_ff @(posedge MCLK)
   begin
      if (RST)
         state_r <= ST_IDLE;
      else
      begin
         unique case (state_r)
            ST_IDLE:
               if (div_start)
                  state_r <= ST_DIV;
            ST_DIV:
               if (div_done)
                  state_r <= ST_DONE;
            ST_DONE:
               state_r <= ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         DONE <= 1'b0;
         ILLEGAL <= 1'b0;
         WRITE_EN <= 1'b0;
         RESULT <= 16'h0000;
      end
      else
      begin
         DONE <= 1'b0;
         ILLEGAL <= 1'b0;
         WRITE_EN <= 1'b0;
         if ((START && state_r == ST_IDLE && OP != OP_DIVIDE) ||
             (state_r == ST_DIV && div_done))
         begin
            DONE <= 1'b1;
            ILLEGAL <= bad_nxt;
            WRITE_EN <= wr_nxt;
            RESULT <= res_nxt;
         end
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (RST)
         flag_word_r <= FLAGS_RESET;
      else if ((START && state_r == ST_IDLE && OP != OP_DIVIDE) ||
               (state_r == ST_DIV && div_done))
         flag_word_r <= flag_nxt; // RQ21
   end

   assign FLAGS = flag_word_r;
endmodule : cpualu_unit

// ===== hw/cpualu_pkg.sv
// package for the arithmetic, logic and shift unit
// assumes the decoder drives operation codes from the enum below
package cpualu_pkg;
   typedef enum logic [4:0] {
      OP_ADD            = 5'h00,
      OP_SUB            = 5'h01,
      OP_ADD_WITH_CARRY = 5'h02,
      OP_SUB_WITH_BORROW = 5'h03,
      OP_PLUS_ONE       = 5'h04,
      OP_MINUS_ONE      = 5'h05,
      OP_WORD_PLUS      = 5'h06,
      OP_WORD_MINUS     = 5'h07,
      OP_BCD_FIX_ADD    = 5'h08,
      OP_BCD_FIX_SUB    = 5'h09,
      OP_MULTIPLY       = 5'h0A,
      OP_DIVIDE         = 5'h0B,
      OP_COMPARE        = 5'h0C,
      OP_NEGATE         = 5'h0D,
      OP_AND            = 5'h0E,
      OP_OR             = 5'h0F,
      OP_XOR            = 5'h10,
      OP_NOT            = 5'h11,
      OP_ARITH_LEFT     = 5'h12,
      OP_ARITH_RIGHT    = 5'h13,
      OP_LOGIC_LEFT     = 5'h14,
      OP_LOGIC_RIGHT    = 5'h15,
      OP_CIRC_LEFT      = 5'h16,
      OP_CIRC_RIGHT     = 5'h17,
      OP_CARRY_LEFT     = 5'h18,
      OP_CARRY_RIGHT    = 5'h19
   } cpualu_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DIV  = 2'b01,
      ST_DONE = 2'b11
   } cpualu_state_t;

   localparam int FLAG_C = 0;
   localparam int FLAG_V = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam int DIV_STEPS = 8;
endpackage : cpualu_pkg

// ===== hw/cpualu_divider.sv
// restoring divider, 16 by 8 unsigned, one quotient bit per clock
// assumes start is a one-cycle pulse while not busy
`timescale 1ns/1ps
module cpualu_divider
#(
   parameter int STEPS = cpualu_pkg::DIV_STEPS
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [15:0] dividend,
   input wire logic [7:0] divisor,
   output logic done,
   output logic [7:0] quotient,
   output logic [7:0] remainder
);
   import cpualu_pkg::*;

   logic [16:0] rem_r;
   logic [7:0] quo_r;
   logic [7:0] dvs_r;
   logic [3:0] cnt_r;
   logic busy_r;
   logic [16:0] shifted;
   logic [16:0] trial;

   if (STEPS != 8)
   begin : g_bad_steps
      $error("divider supports 8 steps only");
   end

   // next dividend bit enters just below the partial remainder
   assign shifted = {rem_r[15:8], quo_r[7], 8'h00};
   assign trial = shifted - {1'b0, dvs_r, 8'h00};

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy_r)
         begin
            busy_r <= 1'b1;
            cnt_r <= 4'h0;
         end
         else if (busy_r)
         begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'(STEPS - 1))
            begin
               busy_r <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

   // remainder kept in bits 15:8 of rem_r, compared against divisor
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rem_r <= 17'h00000;
         quo_r <= 8'h00;
         dvs_r <= 8'h00;
      end
      else if (start && !busy_r)
      begin
         rem_r <= {9'h000, dividend[15:8]} << 8;
         quo_r <= dividend[7:0];
         dvs_r <= divisor;
      end
      else if (busy_r)
      begin
         if (!trial[16])
         begin
            rem_r <= trial;
            quo_r <= {quo_r[6:0], 1'b1};
         end
         else
         begin
            rem_r <= shifted;
            quo_r <= {quo_r[6:0], 1'b0};
         end
      end
   end

   assign quotient = quo_r;
   assign remainder = rem_r[15:8];
endmodule : cpualu_divider

// ===== test/cpualu_asserts.sv
// port assertions for the arithmetic, logic and shift unit
// assumes one clock MCLK and the synchronous reset RST
`timescale 1ns/1ps
module cpualu_asserts
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic START,
   input wire cpualu_pkg::cpualu_op_t OP,
   input wire logic WORD,
   input wire logic USE_IMM,
   input wire logic [15:0] DST_IN,
   input wire logic [15:0] SRC_IN,
   input wire logic DONE,
   input wire logic ILLEGAL,
   input wire logic WRITE_EN,
   input wire logic [15:0] RESULT,
   input wire logic [3:0] FLAGS
);
   import cpualu_pkg::*;
   logic busy_r;
   logic go;
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);
   // a request is only taken while no divide is running
   assign go = START && !busy_r;
   always_ff @(posedge MCLK)
   begin
      if (RST)
         busy_r <= 1'b0;
      else if (go && OP == OP_DIVIDE)
         busy_r <= 1'b1;
      else if (DONE)
         busy_r <= 1'b0;
   end
   a_single_answer: assert property (
      go && OP != OP_DIVIDE |=> DONE)
      else $error("answer not one cycle after request");
   a_div_latency: assert property (
      go && OP == OP_DIVIDE |=> !DONE[*8] ##1 !DONE ##1 DONE)
      else $error("divide answer off its slot");
   a_illegal_quiet: assert property (
      ILLEGAL |-> DONE && !WRITE_EN && $stable(FLAGS))
      else $error("refused form wrote or moved flags");
   a_sub_imm: assert property (
      go && OP == OP_SUB && USE_IMM |=> ILLEGAL)
      else $error("immediate subtract accepted");
   a_word_imm: assert property (
      go && WORD && USE_IMM && OP inside {OP_ADD, OP_SUB, OP_COMPARE}
      |=> ILLEGAL)
      else $error("word immediate form accepted");
   a_cmp_nowrite: assert property (
      go && OP == OP_COMPARE |=> DONE && !WRITE_EN)
      else $error("compare wrote destination");
   a_inc_value: assert property (
      go && OP == OP_PLUS_ONE |=> RESULT[7:0] == $past(DST_IN[7:0]) + 8'h01)
      else $error("increment off");
   a_mul_value: assert property (
      go && OP == OP_MULTIPLY
      |=> RESULT == $past(DST_IN[7:0]) * $past(SRC_IN[7:0]))
      else $error("product wrong");
   a_logic_flags: assert property (
      go && OP inside {OP_AND, OP_OR, OP_XOR, OP_NOT}
      |=> FLAGS[FLAG_N] == RESULT[7] && FLAGS[FLAG_Z] == (RESULT[7:0] == 8'h00))
      else $error("logic flags wrong");
   a_right_shift: assert property (
      go && OP == OP_ARITH_RIGHT
      |=> RESULT[7:0] == {$past(DST_IN[7]), $past(DST_IN[7:1])}
      && FLAGS[FLAG_C] == $past(DST_IN[0]))
      else $error("arithmetic right shift wrong");
endmodule : cpualu_asserts
bind cpualu_unit cpualu_asserts cpualu_asserts_i (.MCLK(MCLK), .RST(RST),
   .START(START), .OP(OP), .WORD(WORD), .USE_IMM(USE_IMM), .DST_IN(DST_IN),
   .SRC_IN(SRC_IN), .DONE(DONE), .ILLEGAL(ILLEGAL), .WRITE_EN(WRITE_EN),
   .RESULT(RESULT), .FLAGS(FLAGS));

// ===== test/cpualu_regfile_model.sv
// general register file standing in for the decoder side
// assumes the bench loads operands; results come back on we
`timescale 1ns/1ps
module cpualu_regfile_model
(
   input wire logic clk,
   input wire logic ld,
   input wire logic [2:0] ld_idx,
   input wire logic [15:0] ld_val,
   input wire logic [2:0] rd_idx,
   input wire logic [2:0] rs_idx,
   input wire logic we,
   input wire logic [15:0] wr_val,
   output logic [15:0] rd_val,
   output logic [15:0] rs_val
);
   logic [15:0] regs [0:7];
   // operands stay put until the answer is written back
   always_ff @(posedge clk)
   begin
      if (ld)
         regs[ld_idx] <= ld_val;
      else if (we)
         regs[rd_idx] <= wr_val;
   end
   assign rd_val = regs[rd_idx];
   assign rs_val = regs[rs_idx];
endmodule : cpualu_regfile_model

// ===== test/cpualu_unit_tb.sv
// self-checking bench for the arithmetic, logic and shift unit
// assumes destination in register 0 and source in register 1
`timescale 1ns/1ps
module cpualu_unit_tb;
   import cpualu_pkg::*;
   logic mclk, rst, start, word, use_imm, sub_two, ld, ld_sel;
   logic done, illegal, write_en, ill, we;
   cpualu_op_t op;
   logic [7:0] imm;
   logic [15:0] dst, src, ld_val, result, res;
   logic [3:0] flags, fl;
   int error_cnt;
   int n_tests;

   cpualu_unit cpualu_unit_i (.MCLK(mclk), .RST(rst), .START(start),
      .OP(op), .WORD(word), .USE_IMM(use_imm), .SUB_TWO(sub_two),
      .DST_IN(dst), .SRC_IN(src), .IMM(imm), .DONE(done),
      .ILLEGAL(illegal), .WRITE_EN(write_en), .RESULT(result),
      .FLAGS(flags));
   cpualu_regfile_model cpualu_regfile_model_i (.clk(mclk), .ld(ld),
      .ld_idx({2'b00, ld_sel}), .ld_val(ld_val), .rd_idx(3'h0),
      .rs_idx(3'h1), .we(write_en), .wr_val(result), .rd_val(dst),
      .rs_val(src));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic cf(input int b, input logic e);
      chk($sformatf("flag%0d", b), {15'h0000, fl[b]}, {15'h0000, e});
   endtask : cf

   task automatic load(input logic [15:0] d, input logic [15:0] s);
      ld = 1'b1;
      ld_sel = 1'b0;
      ld_val = d;
      @(posedge mclk);
      #1;
      ld_sel = 1'b1;
      ld_val = s;
      @(posedge mclk);
      #1;
      ld = 1'b0;
   endtask : load

   // one request, then wait for the answer and its write-back edge
   task automatic exec(input cpualu_op_t o, input logic w, input logic i,
      input logic [7:0] v);
      int k;
      op = o;
      word = w;
      use_imm = i;
      imm = v;
      start = 1'b1;
      @(posedge mclk);
      #1;
      start = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20)
      begin
         @(posedge mclk);
         #1;
         k++;
      end
      if (k == 20)
      begin
         error_cnt++;
         report_and_stop();
      end
      res = result;
      fl = flags;
      ill = illegal;
      we = write_en;
      @(posedge mclk);
      #1;
   endtask : exec

   task automatic xr(input cpualu_op_t o, input logic w, input logic i,
      input logic [7:0] v, input logic [15:0] e);
      exec(o, w, i, v);
      chk(o.name(), res, e);
      chk("wr_ok", {14'h0000, we, ill}, 16'h0002);
   endtask : xr

   task automatic t_arith;
      load(16'h8000, 16'h8001);
      xr(OP_ADD, 1'b1, 1'b0, 8'h00, 16'h0001);
      cf(FLAG_C, 1'b1);
      xr(OP_ADD_WITH_CARRY, 1'b0, 1'b0, 8'h00, 16'h0003);
      load(16'h0010, 16'h0011);
      xr(OP_SUB, 1'b0, 1'b0, 8'h00, 16'h00FF);
      cf(FLAG_N, 1'b1);
      xr(OP_SUB_WITH_BORROW, 1'b0, 1'b1, 8'h0F, 16'h00EF);
      xr(OP_ADD, 1'b0, 1'b1, 8'h11, 16'h0000);
      cf(FLAG_Z, 1'b1);
      load(16'h12FF, 16'h0000);
      xr(OP_PLUS_ONE, 1'b0, 1'b0, 8'h00, 16'h1200);
      xr(OP_MINUS_ONE, 1'b0, 1'b0, 8'h00, 16'h12FF);
      sub_two = 1'b1;
      xr(OP_WORD_PLUS, 1'b0, 1'b0, 8'h00, 16'h1301);
      sub_two = 1'b0;
      xr(OP_WORD_MINUS, 1'b0, 1'b0, 8'h00, 16'h1300);
      chk("reg", dst, 16'h1300);
      load(16'h0015, 16'h0027);
      xr(OP_ADD, 1'b0, 1'b0, 8'h00, 16'h003C);
      xr(OP_BCD_FIX_ADD, 1'b0, 1'b0, 8'h00, 16'h0042);
      load(16'h0015, 16'h0027);
      xr(OP_SUB, 1'b0, 1'b0, 8'h00, 16'h00EE);
      xr(OP_BCD_FIX_SUB, 1'b0, 1'b0, 8'h00, 16'h0088);
      cf(FLAG_C, 1'b1);
      $display("arith done");
   endtask : t_arith

   task automatic t_muldiv;
      load(16'h00FF, 16'h00FF);
      xr(OP_MULTIPLY, 1'b0, 1'b0, 8'h00, 16'hFE01);
      load(16'h1234, 16'h0056);
      xr(OP_DIVIDE, 1'b0, 1'b0, 8'h00, 16'h1036);
      load(16'h0005, 16'h0007);
      exec(OP_COMPARE, 1'b0, 1'b0, 8'h00);
      chk("cmp_we", {15'h0000, we}, 16'h0000);
      cf(FLAG_C, 1'b1);
      chk("reg", dst, 16'h0005);
      exec(OP_COMPARE, 1'b0, 1'b1, 8'h05);
      cf(FLAG_Z, 1'b1);
      xr(OP_NEGATE, 1'b0, 1'b0, 8'h00, 16'h00FB);
      $display("muldiv done");
   endtask : t_muldiv

   task automatic t_logic;
      cpualu_op_t lo [4] = '{OP_AND, OP_OR, OP_XOR, OP_NOT};
      logic [7:0] le [4] = '{8'h30, 8'hFC, 8'hCC, 8'hC3};
      for (int k = 0; k < 4; k++)
      begin
         load(16'hAB3C, 16'h00F0);
         xr(lo[k], 1'b0, 1'b0, 8'h00, {8'hAB, le[k]});
         cf(FLAG_N, le[k][7]);
      end
      xr(OP_AND, 1'b0, 1'b1, 8'h0F, 16'hAB03);
      xr(OP_XOR, 1'b0, 1'b1, 8'h03, 16'hAB00);
      cf(FLAG_Z, 1'b1);
      xr(OP_OR, 1'b0, 1'b1, 8'h81, 16'hAB81);
      $display("logic done");
   endtask : t_logic

   task automatic t_shift;
      cpualu_op_t so [8] = '{OP_ARITH_LEFT, OP_CARRY_LEFT, OP_CARRY_RIGHT,
         OP_ARITH_RIGHT, OP_LOGIC_RIGHT, OP_LOGIC_LEFT, OP_CIRC_LEFT,
         OP_CIRC_RIGHT};
      logic [7:0] sd [8] = '{8'h41, 8'h80, 8'h02, 8'h81, 8'h81, 8'h40,
         8'h81, 8'h02};
      logic [7:0] se [8] = '{8'h82, 8'h00, 8'h81, 8'hC0, 8'h40, 8'h80,
         8'h03, 8'h01};
      logic [7:0] sc = 8'h5A;
      // each carry-loop entry takes the carry left by the entry before
      for (int k = 0; k < 8; k++)
      begin
         load({8'h00, sd[k]}, 16'h0000);
         xr(so[k], 1'b0, 1'b0, 8'h00, {8'h00, se[k]});
         cf(FLAG_C, sc[k]);
      end
      $display("shift done");
   endtask : t_shift

   task automatic t_illegal;
      cpualu_op_t io [3] = '{OP_SUB, OP_ADD, OP_COMPARE};
      logic [3:0] f0;
      for (int k = 0; k < 3; k++)
      begin
         load(16'h0050, 16'h0003);
         f0 = flags;
         exec(io[k], k != 0, 1'b1, 8'h01);
         chk("ill", {15'h0000, ill}, 16'h0001);
         chk("flags", {12'h000, fl}, {12'h000, f0});
         chk("reg", dst, 16'h0050);
      end
      $display("illegal done");
   endtask : t_illegal

   initial
   begin
      error_cnt = 0;
      n_tests = 0;
      rst = 1'b1;
      start = 1'b0;
      op = OP_ADD;
      word = 1'b0;
      use_imm = 1'b0;
      sub_two = 1'b0;
      imm = 8'h00;
      ld = 1'b0;
      ld_sel = 1'b0;
      ld_val = 16'h0000;
      repeat (3) @(posedge mclk);
      #1;
      rst = 1'b0;
      chk("reset", {12'h000, flags}, 16'h0000);
      t_arith();
      t_muldiv();
      t_logic();
      t_shift();
      t_illegal();
      report_and_stop();
   end
endmodule : cpualu_unit_tb
